// >>> hw/csf_consts.vh
// Function
// - Charge-state pin floats when charge monitor select equals 11.
// - Pin low while charging; high when complete, sleeping or disabled.
// - Pin toggles at 1 Hz during input or system overvoltage, thermistor or timer faults.
// - Reportable events emit 256 us interrupt pulses; events in one cycle, or queued during one pulse, share one.
// - Pulses on source type, good source, removal, done, faults, unmasked limits.
// - Charge and battery faults pulse interrupt and stay latched until the fault register is read.
// - No further non-boost fault interrupts until register read and faults cleared.
// - First read returns latched faults; second read returns present faults.
// - Input overvoltage stops switching, sets charge fault 01, pulses interrupt.
// - Input overvoltage recovery is automatic when voltage falls back.
// - System overvoltage stops switching and enables 30 mA discharge.
// - Boost short retries 7 times, then clears boost enable, sets fault.
// - Boost fault flag clears when host re-enables boost.
// - Boost overvoltage stops switching, clears enable, sets boost fault.
// - Thermal regulation cuts current, inhibits termination, halves timer, flags.
// - Thermal shutdown stops converter and switch, sets code, pulses, recovers.
// - Boost thermal shutdown clears boost enable and opens switch until cool.
// - Battery overvoltage disables charging, sets battery fault, pulses.
// - Depletion latches switch off until plug-in; short or precharge current.
// - Switch overcurrent latches switch off until shipping-mode exit events.
// - Safety timer expiry sets charge fault code 11 and pulses.
// - Thermistor fault field always shows the live condition.
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH
`define CSF_CLK_HZ 20000000
`define CSF_PULSE_US 256
`define CSF_BLINK_HZ 1
`define CSF_RETRY_MAX 3'h7
`define CSF_MON_OFF 2'h3
`define CSF_CF_NONE 2'h0
`define CSF_CF_INPUT 2'h1
`define CSF_CF_THERM 2'h2
`define CSF_CF_TIMER 2'h3
`define CSF_ADDR_FAULT 4'h9
`define CSF_ADDR_CTRL 4'h0
`define CSF_ADDR_BOOST 4'h1
`define CSF_ADDR_STAT 4'h8
`define CSF_CTRL_RST 8'h00
`endif

// >>> hw/csf_pulse.v
`timescale 1ns/1ps
`include "csf_consts.vh"
// Stretches a one-cycle request into a fixed high pulse on pulse_o followed by a
// low gap one cycle longer; requests arriving while busy are held pending.
module csf_pulse #(
  parameter WIDTH = 5120
) (
  input wire clk_i,
  input wire rst_i,
  input wire req_i,
  output reg pulse_o
);
  reg [15:0] cnt_reg;
  reg pend_reg;
  reg gap_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      pend_reg <= 1'b0;
      gap_reg <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      if (req_i)
        pend_reg <= 1'b1;
      if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end else if (pulse_o) begin
        pulse_o <= 1'b0;
        gap_reg <= 1'b1;
        cnt_reg <= WIDTH[15:0] - 16'h0001;
      end else if (gap_reg) begin
        gap_reg <= 1'b0;
      end else if (pend_reg || req_i) begin
        pulse_o <= 1'b1;
        pend_reg <= 1'b0;
        cnt_reg <= WIDTH[15:0] - 16'h0001;
      end
    end
  end
endmodule

// >>> hw/csf_top.v
`timescale 1ns/1ps
`include "csf_consts.vh"
module csf_top #(
  parameter PULSE_CYC = (`CSF_CLK_HZ / 1000000) * `CSF_PULSE_US,
  parameter BLINK_HALF = `CSF_CLK_HZ / (2 * `CSF_BLINK_HZ)
) (
  // Clock and reset.
  input wire CLOCK_I,
  input wire SYS_RST_I,
  // Register port.
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  // Charger state.
  input wire CHARGING_I,
  input wire CHG_DONE_I,
  input wire SRC_TYPE_DONE_I,
  input wire GOOD_SRC_I,
  input wire INPUT_REMOVED_I,
  input wire VLIMIT_EVT_I,
  input wire ILIMIT_EVT_I,
  input wire BOOST_MODE_I,
  // Protection monitors, levels.
  input wire INPUT_OV_I,
  input wire SYS_OV_I,
  input wire BAT_OV_I,
  input wire BOOST_SHORT_I,
  input wire BOOST_OV_I,
  input wire TJ_REG_I,
  input wire TJ_SHUT_I,
  input wire TJ_COOL_I,
  input wire THERM_FAULT_I,
  input wire TIMER_EXP_I,
  input wire BAT_DEPLETED_I,
  input wire BAT_SHORT_I,
  input wire SW_OC_I,
  input wire SHIP_EXIT_I,
  input wire PLUG_IN_I,
  // Pins, open drain: enable low drives low.
  output reg STAT_OE_N_O,
  output reg INT_OE_N_O,
  // Power stage controls.
  output reg SWITCH_STOP_O,
  output reg SYS_DISCHG_O,
  output reg BOOST_EN_O,
  output reg BAT_SW_ON_O,
  output reg CHG_DISABLE_O,
  output reg CUR_REDUCE_O,
  output reg TERM_INHIBIT_O,
  output reg TIMER_HALF_O,
  output reg SHORT_CUR_O,
  output reg PRECHG_CUR_O
);
  reg [1:0] mon_sel_reg;
  reg vlim_mask_reg;
  reg ilim_mask_reg;
  reg boost_short_d_reg;
  reg [2:0] retry_reg;
  reg [1:0] cf_live;
  reg [7:0] fault_live;
  reg [7:0] fault_lat_reg;
  reg fault_lock_reg;
  reg tshut_reg;
  reg dep_latch_reg;
  reg oc_latch_reg;
  reg [24:0] blink_cnt_reg;
  reg blink_reg;
  reg [7:0] prev_ev_reg;
  reg [7:0] ev_now;
  reg fault_new;
  reg int_req;
  wire int_pulse;
  wire rd_fault;
  wire boost_fail;

  function [7:0] rising;
    input [7:0] now;
    input [7:0] was;
    begin
      rising = now & ~was;
    end
  endfunction

  assign rd_fault = RD_I && (ADDR_I == `CSF_ADDR_FAULT);
  assign boost_fail = BOOST_SHORT_I && !boost_short_d_reg &&
                      (retry_reg == `CSF_RETRY_MAX);

  always @* begin
    cf_live = `CSF_CF_NONE;
    if (TIMER_EXP_I)
      cf_live = `CSF_CF_TIMER;
    if (tshut_reg)
      cf_live = `CSF_CF_THERM;
    if (INPUT_OV_I)
      cf_live = `CSF_CF_INPUT;
    // Bit 6 boost fault, 5:4 charge code, 3 battery, 2:0 thermistor.
    fault_live = {1'b0, fault_lat_reg[6], cf_live, BAT_OV_I, 2'b00,
                  THERM_FAULT_I};
    ev_now = {SRC_TYPE_DONE_I, GOOD_SRC_I, INPUT_REMOVED_I, CHG_DONE_I,
              VLIMIT_EVT_I & ~vlim_mask_reg, ILIMIT_EVT_I & ~ilim_mask_reg,
              2'b00};
    fault_new = (INPUT_OV_I | tshut_reg | TIMER_EXP_I | BAT_OV_I |
                 THERM_FAULT_I) & ~fault_lock_reg;
    int_req = (|rising(ev_now, prev_ev_reg)) | fault_new | boost_fail |
              (BOOST_OV_I & BOOST_EN_O);
  end

  csf_pulse #(
    .WIDTH(PULSE_CYC)
  ) u_pulse (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .req_i(int_req),
    .pulse_o(int_pulse)
  );

  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      mon_sel_reg <= 2'h0;
      vlim_mask_reg <= 1'b0;
      ilim_mask_reg <= 1'b0;
      boost_short_d_reg <= 1'b0;
      retry_reg <= 3'h0;
      fault_lat_reg <= 8'h00;
      fault_lock_reg <= 1'b0;
      tshut_reg <= 1'b0;
      dep_latch_reg <= 1'b0;
      oc_latch_reg <= 1'b0;
      blink_cnt_reg <= 25'h0000000;
      blink_reg <= 1'b0;
      prev_ev_reg <= 8'h00;
      RDATA_O <= 8'h00;
      STAT_OE_N_O <= 1'b1;
      INT_OE_N_O <= 1'b1;
      SWITCH_STOP_O <= 1'b0;
      SYS_DISCHG_O <= 1'b0;
      BOOST_EN_O <= 1'b0;
      BAT_SW_ON_O <= 1'b1;
      CHG_DISABLE_O <= 1'b0;
      CUR_REDUCE_O <= 1'b0;
      TERM_INHIBIT_O <= 1'b0;
      TIMER_HALF_O <= 1'b0;
      SHORT_CUR_O <= 1'b0;
      PRECHG_CUR_O <= 1'b0;
    end else begin
      prev_ev_reg <= ev_now;
      boost_short_d_reg <= BOOST_SHORT_I;
      INT_OE_N_O <= ~int_pulse;
      // Thermal shutdown holds until the cool-down point is crossed.
      if (TJ_SHUT_I)
        tshut_reg <= 1'b1;
      else if (TJ_COOL_I)
        tshut_reg <= 1'b0;
      // Register writes; a boost re-enable clears the boost fault.
      if (WR_I && ADDR_I == `CSF_ADDR_CTRL) begin
        mon_sel_reg <= WDATA_I[6:5];
        vlim_mask_reg <= WDATA_I[1];
        ilim_mask_reg <= WDATA_I[0];
      end
      if (BOOST_SHORT_I && !boost_short_d_reg)
        retry_reg <= (retry_reg == `CSF_RETRY_MAX) ? 3'h0 :
                     retry_reg + 3'h1;
      if (!BOOST_EN_O)
        retry_reg <= 3'h0;
      if (WR_I && ADDR_I == `CSF_ADDR_BOOST && WDATA_I[0]) begin
        BOOST_EN_O <= 1'b1;
        fault_lat_reg[6] <= 1'b0;
      end else if (WR_I && ADDR_I == `CSF_ADDR_BOOST) begin
        BOOST_EN_O <= 1'b0;
      end
      if (boost_fail || (BOOST_OV_I && BOOST_EN_O) ||
          (TJ_SHUT_I && BOOST_MODE_I)) begin
        BOOST_EN_O <= 1'b0;
        if (!TJ_SHUT_I || boost_fail || BOOST_OV_I)
          fault_lat_reg[6] <= 1'b1;
      end
      // Fault register: read returns latched state, then relatches live.
      if (rd_fault) begin
        RDATA_O <= {fault_lat_reg[7:3], 2'b00, THERM_FAULT_I};
        fault_lat_reg[5:0] <= fault_live[5:0];
        fault_lock_reg <= |fault_live[5:0];
      end else begin
        if (RD_I && ADDR_I == `CSF_ADDR_STAT)
          RDATA_O <= {CUR_REDUCE_O, BAT_SW_ON_O, BOOST_EN_O, 3'h0,
                      mon_sel_reg};
        else if (RD_I && ADDR_I == `CSF_ADDR_CTRL)
          RDATA_O <= {1'b0, mon_sel_reg, 3'h0, vlim_mask_reg, ilim_mask_reg};
        else if (RD_I && ADDR_I == `CSF_ADDR_BOOST)
          RDATA_O <= {7'h00, BOOST_EN_O};
        else if (RD_I)
          RDATA_O <= 8'hff;
        if (|fault_new)
          fault_lock_reg <= 1'b1;
        // Charge code keeps its first value and the battery flag accumulates; thermistor bits follow live.
        fault_lat_reg[5:4] <= (fault_lat_reg[5:4] != `CSF_CF_NONE) ?
                              fault_lat_reg[5:4] : cf_live;
        fault_lat_reg[3] <= fault_lat_reg[3] | BAT_OV_I;
        fault_lat_reg[2:0] <= {2'b00, THERM_FAULT_I};
      end
      SWITCH_STOP_O <= INPUT_OV_I | SYS_OV_I | tshut_reg |
                       (BOOST_OV_I & BOOST_MODE_I);
      SYS_DISCHG_O <= SYS_OV_I;
      CHG_DISABLE_O <= BAT_OV_I | tshut_reg;
      CUR_REDUCE_O <= TJ_REG_I & ~BOOST_MODE_I;
      TERM_INHIBIT_O <= TJ_REG_I & ~BOOST_MODE_I;
      TIMER_HALF_O <= TJ_REG_I & ~BOOST_MODE_I;
      // Switch latches: depletion until plug-in, overcurrent until exit or plug-in.
      if (BAT_DEPLETED_I)
        dep_latch_reg <= 1'b1;
      else if (PLUG_IN_I)
        dep_latch_reg <= 1'b0;
      if (SW_OC_I)
        oc_latch_reg <= 1'b1;
      else if (SHIP_EXIT_I || PLUG_IN_I)
        oc_latch_reg <= 1'b0;
      BAT_SW_ON_O <= ~(dep_latch_reg | oc_latch_reg | tshut_reg |
                       BAT_DEPLETED_I | SW_OC_I);
      SHORT_CUR_O <= CHARGING_I & BAT_SHORT_I;
      PRECHG_CUR_O <= CHARGING_I & ~BAT_SHORT_I & BAT_DEPLETED_I;
      // Half-period counter for the 1 Hz blink.
      if (blink_cnt_reg >= BLINK_HALF[24:0] - 25'h0000001) begin
        blink_cnt_reg <= 25'h0000000;
        blink_reg <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 25'h0000001;
      end
      if (mon_sel_reg == `CSF_MON_OFF)
        STAT_OE_N_O <= 1'b1;
      else if (INPUT_OV_I | THERM_FAULT_I | TIMER_EXP_I | SYS_OV_I)
        STAT_OE_N_O <= blink_reg;
      else
        STAT_OE_N_O <= ~(CHARGING_I & ~CHG_DONE_I);
    end
  end
endmodule

// >>> tb/csf_monitor.sv
`timescale 1ns/1ps
module csf_monitor #(
  parameter PULSE_CYC = 5120,
  parameter BLINK_HALF = 2
) (
  // Clock, reset and register writes.
  input wire CLOCK_I, input wire SYS_RST_I, input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I, input wire WR_I,
  // Events, monitors and outputs.
  input wire CHG_DONE_I, input wire GOOD_SRC_I, input wire INPUT_OV_I,
  input wire SYS_OV_I, input wire BAT_OV_I, input wire BOOST_OV_I,
  input wire STAT_OE_N_O, input wire INT_OE_N_O, input wire SWITCH_STOP_O,
  input wire SYS_DISCHG_O, input wire BOOST_EN_O, input wire CHG_DISABLE_O
);
  reg [1:0] mon_reg;
  reg [15:0] low_reg;
  reg [15:0] high_reg;
  // The idle count saturates so that a long quiet spell cannot wrap.
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      mon_reg <= 2'h0;
      low_reg <= 16'h0;
      high_reg <= 16'(PULSE_CYC);
    end else begin
      if (WR_I && ADDR_I == 4'h0)
        mon_reg <= WDATA_I[6:5];
      low_reg <= INT_OE_N_O ? 16'h0 : low_reg + 16'h1;
      high_reg <= !INT_OE_N_O ? 16'h0 : high_reg + {15'h0, ~&high_reg};
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_evt;
    $rose(CHG_DONE_I) || $rose(GOOD_SRC_I);
  endsequence
  sequence s_pulse_due;
    ##[1:24] !INT_OE_N_O;
  endsequence
  AST_INT_EVENT: assert property (s_evt |-> s_pulse_due)
    else $error("event without interrupt pulse");
  AST_INT_WIDTH: assert property (
    $rose(INT_OE_N_O) |-> low_reg == PULSE_CYC) else $error("pulse width");
  AST_INT_GAP: assert property (
    $fell(INT_OE_N_O) |-> high_reg >= PULSE_CYC) else $error("pulse gap");
  AST_STAT_FLOAT: assert property (
    mon_reg == 2'h3 && $past(mon_reg, 2) == 2'h3 |-> STAT_OE_N_O)
    else $error("status pin driven while disabled");
  AST_INOV_STOP: assert property (
    $rose(INPUT_OV_I) |-> ##[1:2] SWITCH_STOP_O) else $error("no stop");
  AST_SYSOV: assert property (
    $rose(SYS_OV_I) |-> ##[1:2] (SWITCH_STOP_O && SYS_DISCHG_O))
    else $error("no stop or discharge");
  AST_BOOST_OV: assert property (
    $rose(BOOST_OV_I) |-> ##[1:2] !BOOST_EN_O) else $error("boost kept on");
  AST_BAT_OV: assert property (
    $rose(BAT_OV_I) |-> ##[1:2] CHG_DISABLE_O) else $error("charge kept on");
endmodule
bind csf_top csf_monitor #(.PULSE_CYC(PULSE_CYC), .BLINK_HALF(BLINK_HALF))
  u_mon (.*);

// >>> tb/csf_host.sv
`timescale 1ns/1ps
// Register-port master standing in for the host processor.
module csf_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg [3:0] addr_o = 4'h0,
  output reg [7:0] wdata_o = 8'h00,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0
);
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task rd(input [3:0] a, output [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
  // Back-to-back fault reads: the second one shows the present state.
  task rd2(output [7:0] d1, output [7:0] d2);
    @(posedge clk_i);
    addr_o <= 4'h9;
    rd_o <= 1'b1;
    @(posedge clk_i);
    #1 d1 = rdata_i;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d2 = rdata_i;
  endtask
endmodule

// >>> tb/test_csf_top.sv
`timescale 1ns/1ps
module test_csf_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [22:0] ev = 23'h0;
  wire [3:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire wr, rd, stat_n, int_n, bat_sw, boost_en;
  reg [7:0] a, b;
  reg s;
  integer err_total = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i, j;
  always #25 clk = ~clk;
  csf_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  csf_top #(.PULSE_CYC(8), .BLINK_HALF(4)) dut (.CLOCK_I(clk),
    .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .CHARGING_I(ev[0]), .CHG_DONE_I(ev[1]),
    .SRC_TYPE_DONE_I(ev[2]), .GOOD_SRC_I(ev[3]), .INPUT_REMOVED_I(ev[4]),
    .VLIMIT_EVT_I(ev[5]), .ILIMIT_EVT_I(ev[6]), .BOOST_MODE_I(ev[7]),
    .INPUT_OV_I(ev[8]), .SYS_OV_I(ev[9]), .BAT_OV_I(ev[10]),
    .BOOST_SHORT_I(ev[11]), .BOOST_OV_I(ev[12]), .TJ_REG_I(ev[13]),
    .TJ_SHUT_I(ev[14]), .TJ_COOL_I(ev[15]), .THERM_FAULT_I(ev[16]),
    .TIMER_EXP_I(ev[17]), .BAT_DEPLETED_I(ev[18]), .BAT_SHORT_I(ev[19]),
    .SW_OC_I(ev[20]), .SHIP_EXIT_I(ev[21]), .PLUG_IN_I(ev[22]),
    .STAT_OE_N_O(stat_n), .INT_OE_N_O(int_n), .SWITCH_STOP_O(),
    .SYS_DISCHG_O(), .BOOST_EN_O(boost_en), .BAT_SW_ON_O(bat_sw),
    .CHG_DISABLE_O(), .CUR_REDUCE_O(), .TERM_INHIBIT_O(), .TIMER_HALF_O(),
    .SHORT_CUR_O(), .PRECHG_CUR_O());
  task set(input integer k, input v);
    @(posedge clk);
    ev[k] <= v;
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Long enough for a queued pulse plus its released gap.
  task wint(input e);
    reg seen;
    integer k;
    seen = 1'b0;
    for (k = 0; k < 30; k = k + 1) begin
      step(1);
      if (int_n === 1'b0) seen = 1'b1;
    end
    chk({7'h0, seen}, {7'h0, e});
  endtask
  task frd(input [7:0] e1, input [7:0] e2);
    host.rd2(a, b);
    chk(a, e1);
    chk(b, e2);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk({5'h0, int_n, stat_n, bat_sw}, 8'h07);
    set(0, 1'b1); step(3); chk({7'h0, stat_n}, 8'h00);
    host.wr(4'h0, 8'h60); step(3); chk({7'h0, stat_n}, 8'h01);
    host.wr(4'h0, 8'h03);
    set(0, 1'b0);
    for (i = 1; i < 7; i = i + 1) begin
      set(i, 1'b1); wint(i < 5); set(i, 1'b0);
    end
    host.wr(4'h0, 8'h00);
    for (i = 5; i < 7; i = i + 1) begin
      set(i, 1'b1); wint(1'b1); set(i, 1'b0);
    end
    chk({7'h0, stat_n}, 8'h01);
    $display("test 1 finished");
    set(0, 1'b1);
    for (j = 0; j < 3; j = j + 1) begin
      i = j == 0 ? 8 : (j == 1 ? 14 : 17);
      set(i, 1'b1); wint(1'b1);
      s = stat_n;
      step(4);
      if (j != 1) chk({7'h0, s ^ stat_n}, 8'h01);
      chk({7'h0, bat_sw}, {7'h0, j != 1});
      set(i, 1'b0); set(15, 1'b1); step(3);
      chk({7'h0, bat_sw}, 8'h01);
      set(15, 1'b0);
      frd(8'((j + 1) << 4), 8'h00);
    end
    set(8, 1'b1); wint(1'b1);
    set(10, 1'b1); wint(1'b0);
    set(8, 1'b0); set(10, 1'b0);
    frd(8'h18, 8'h00);
    set(9, 1'b1); set(13, 1'b1); step(30);
    host.rd(4'h8, a); chk({7'h0, a[7]}, 8'h01);
    set(9, 1'b0); set(13, 1'b0); set(0, 1'b0); step(30);
    host.rd2(a, b);
    $display("test 2 finished");
    set(16, 1'b1); step(30); host.rd(4'h9, a);
    chk({7'h0, a[0]}, 8'h01);
    set(16, 1'b0); step(2); host.rd(4'h9, a);
    chk({7'h0, a[0]}, 8'h00);
    host.rd2(a, b);
    host.wr(4'h1, 8'h01); set(7, 1'b1); step(3);
    chk({7'h0, boost_en}, 8'h01);
    set(12, 1'b1); wint(1'b1);
    chk({7'h0, boost_en}, 8'h00);
    set(12, 1'b0);
    frd(8'h40, 8'h40);
    host.wr(4'h1, 8'h01); host.rd2(a, b); chk(b, 8'h00);
    // Seven short detections are retried; the eighth gives up boost.
    for (i = 0; i < 7; i = i + 1) begin
      set(11, 1'b1); set(11, 1'b0);
    end
    chk({7'h0, boost_en}, 8'h01);
    set(11, 1'b1); wint(1'b1); set(11, 1'b0);
    chk({7'h0, boost_en}, 8'h00);
    frd(8'h40, 8'h40);
    set(7, 1'b0);
    $display("test 3 finished");
    for (j = 0; j < 2; j = j + 1) begin
      i = j ? 20 : 18;
      set(i, 1'b1); step(3); set(i, 1'b0); step(3);
      chk({7'h0, bat_sw}, 8'h00);
      set(i + (j ? 1 : 4), 1'b1); step(3);
      chk({7'h0, bat_sw}, 8'h01);
      set(i + (j ? 1 : 4), 1'b0);
    end
    host.rd(4'hf, a); chk(a, 8'hff);
    $display("test 4 finished");
    complete_run;
  end
endmodule
